// ### rtl/sld_ctrl.sv
// Serial LED display controller: link shifter, register file and scanner
`timescale 1ns/1ns
module sld_ctrl
    import sld_pkg::*;
#(
    parameter int WAKE_COUNT  = WAKE_CYCLES,
    parameter int DIGIT_COUNT = DIGIT_CYCLES
)
(
    // System
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    // Serial link, clocked by the host
    input  wire logic       link_clk_in,
    input  wire logic       serial_data_in,
    input  wire logic       latch_strobe_in,
    output logic            serial_data_out,
    output logic            serial_data_oe_out,
    // Display drive
    output logic [7:0]      digit_sink_lines_out,
    output logic [6:0]      segment_source_lines_out,
    output logic            decimal_point_out
);
    // Link domain: shifter and falling-edge output stage
    logic [FRAME_BITS-1:0] shift_reg;
    logic                  tail_bit;
    logic                  out_bit;

    always_ff @(posedge link_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            shift_reg <= '0;
            tail_bit  <= 1'b0;
        end
        else
        begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], serial_data_in};
            tail_bit  <= shift_reg[FRAME_BITS-1];
        end
    end

    // Extra stage so a bit leaves half a cycle after the 16th later edge
    always_ff @(negedge link_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            out_bit <= 1'b0;
        else
            out_bit <= tail_bit;
    end

    assign serial_data_out    = out_bit;
    assign serial_data_oe_out = 1'b1;

    // Frame captured on latch rise; strobe holds it stable for the crossing
    sld_write_t frame_hold;
    logic       frame_toggle;

    always_ff @(posedge latch_strobe_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            frame_hold   <= '0;
            frame_toggle <= 1'b0;
        end
        else
        begin
            // Host timing keeps the shifter still at this edge
            frame_hold   <= {shift_reg[ADDR_MSB:ADDR_LSB],
                             shift_reg[7:0]};
            frame_toggle <= ~frame_toggle;
        end
    end

    // System domain state
    typedef struct packed {
        logic [2:0]  tog_sync;
        sld_write_t  wr;
        logic        wr_go;
        logic [63:0] digits;
        logic [7:0]  decode_sel;
        logic [3:0]  bright;
        logic [2:0]  scan_lim;
        logic        run_req;
        logic        test_on;
        sld_mode_t   mode;
        logic [15:0] wake_cnt;
        logic [15:0] dig_cnt;
        logic [2:0]  dig_idx;
        logic [4:0]  pwm_slot;
        sld_pins_t   pins;
    } sld_state_t;

    sld_state_t st;
    sld_state_t next_st;

    localparam logic [15:0] WAKE_LAST  = 16'(WAKE_COUNT - 1);
    localparam logic [15:0] DIGIT_LAST = 16'(DIGIT_COUNT / PWM_STEPS - 1);

    function automatic logic [6:0] font(input logic [3:0] code);
        case (code)
            4'h0:    font = 7'h7E;
            4'h1:    font = 7'h30;
            4'h2:    font = 7'h6D;
            4'h3:    font = 7'h79;
            4'h4:    font = 7'h33;
            4'h5:    font = 7'h5B;
            4'h6:    font = 7'h5F;
            4'h7:    font = 7'h70;
            4'h8:    font = 7'h7F;
            4'h9:    font = 7'h7B;
            4'hA:    font = 7'h01;
            4'hB:    font = 7'h4F;
            4'hC:    font = 7'h37;
            4'hD:    font = 7'h0E;
            4'hE:    font = 7'h67;
            default: font = 7'h00;
        endcase
    endfunction

    logic [7:0] cur_byte;
    logic [6:0] cur_seg;
    logic       lit;
    logic       shown;

    always_comb
    begin
        next_st = st;
        next_st.tog_sync = {st.tog_sync[1:0], frame_toggle};
        next_st.wr_go = st.tog_sync[2] ^ st.tog_sync[1];
        if (st.tog_sync[2] ^ st.tog_sync[1])
            next_st.wr = frame_hold;

        // Writes land in every mode, shutdown included
        if (st.wr_go)
        begin
            case (st.wr.addr)
                ADR_DECODE:    next_st.decode_sel = st.wr.data;
                ADR_BRIGHT:    next_st.bright = st.wr.data[3:0];
                ADR_SCAN:      next_st.scan_lim = st.wr.data[2:0];
                ADR_POWER:
                    next_st.run_req = st.wr.data[POWER_RUN_BIT];
                ADR_TEST:      next_st.test_on = st.wr.data[TEST_BIT];
                ADR_RESET_EXT:
                begin
                    if (st.wr.data[SOFT_RST_BIT])
                    begin
                        next_st.digits     = '0;
                        next_st.decode_sel = RST_BYTE;
                        next_st.bright     = 4'h0;
                        next_st.scan_lim   = RST_SCAN;
                        next_st.run_req    = 1'b0;
                    end
                end
                ADR_NOOP, ADR_UNUSED: ;
                default:
                    // Only the addressed byte changes
                    next_st.digits[(st.wr.addr - ADR_DIGIT0) * 8 +: 8]
                        = st.wr.data;
            endcase
        end

        case (st.mode)
            SLD_OFF:
                if (st.run_req)
                begin
                    next_st.mode = SLD_WAKE;
                    next_st.wake_cnt = '0;
                end
            SLD_WAKE:
                if (!st.run_req)
                    next_st.mode = SLD_OFF;
                else if (st.wake_cnt == WAKE_LAST)
                    next_st.mode = SLD_RUN;
                else
                    next_st.wake_cnt = st.wake_cnt + 16'h0001;
            SLD_RUN:
                if (!st.run_req)
                    next_st.mode = SLD_OFF;
            default: next_st.mode = SLD_OFF;
        endcase

        // Digit slot split into PWM slots
        if (st.dig_cnt == DIGIT_LAST)
        begin
            next_st.dig_cnt = '0;
            next_st.pwm_slot = st.pwm_slot + 5'h01;
            if (st.pwm_slot == 5'(PWM_STEPS - 1))
                next_st.dig_idx = (st.dig_idx >= st.scan_lim) ? 3'h0
                                  : st.dig_idx + 3'h1;
        end
        else
            next_st.dig_cnt = st.dig_cnt + 16'h0001;

        cur_byte = st.digits[st.dig_idx * 8 +: 8];
        if (st.test_on)
            cur_byte = 8'hFF;
        if (st.decode_sel[st.dig_idx] && !st.test_on)
            cur_seg = font(cur_byte[3:0]);
        else
            cur_seg = cur_byte[6:0];
        // Duty (2n+1)/32 for intensity n
        lit   = (st.pwm_slot <= {st.bright, 1'b0}) || st.test_on;
        shown = (st.mode == SLD_RUN || st.test_on) && lit;

        next_st.pins.digit_sink_lines = 8'hFF;
        next_st.pins.segment_source_lines = 7'h00;
        next_st.pins.decimal_point = 1'b0;
        if (shown)
        begin
            next_st.pins.digit_sink_lines[st.dig_idx] = 1'b0;
            next_st.pins.segment_source_lines = cur_seg;
            next_st.pins.decimal_point = cur_byte[DP_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st <= '0;
            st.mode <= SLD_OFF;
            st.pins.digit_sink_lines <= 8'hFF;
        end
        else
            st <= next_st;
    end

    assign digit_sink_lines_out     = st.pins.digit_sink_lines;
    assign segment_source_lines_out = st.pins.segment_source_lines;
    assign decimal_point_out        = st.pins.decimal_point;
endmodule // sld_ctrl

// ### rtl/sld_pkg.sv
// Package for the serial LED display controller: constants, states, carriers
package sld_pkg;
    localparam int          FRAME_BITS    = 16;
    localparam int          ADDR_MSB      = 11;
    localparam int          ADDR_LSB      = 8;
    localparam logic [3:0]  ADR_NOOP      = 4'h0;
    localparam logic [3:0]  ADR_DIGIT0    = 4'h1;
    localparam logic [3:0]  ADR_DIGIT7    = 4'h8;
    localparam logic [3:0]  ADR_DECODE    = 4'h9;
    localparam logic [3:0]  ADR_BRIGHT    = 4'hA;
    localparam logic [3:0]  ADR_SCAN      = 4'hB;
    localparam logic [3:0]  ADR_POWER     = 4'hC;
    localparam logic [3:0]  ADR_UNUSED    = 4'hD;
    localparam logic [3:0]  ADR_RESET_EXT = 4'hE;
    localparam logic [3:0]  ADR_TEST      = 4'hF;
    localparam int          POWER_RUN_BIT = 0;
    localparam int          TEST_BIT      = 0;
    localparam int          SOFT_RST_BIT  = 0;
    localparam int          DP_BIT        = 7;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [2:0]  RST_SCAN      = 3'h0;
    localparam int          CLK_HZ        = 25_000_000;
    localparam int          WAKE_US       = 250;
    localparam int          WAKE_CYCLES   = WAKE_US * (CLK_HZ / 1_000_000);
    localparam int          DIGIT_CYCLES  = 3_125;
    localparam int          PWM_STEPS     = 32;

    typedef enum logic [2:0] {
        SLD_OFF  = 3'b001,
        SLD_WAKE = 3'b010,
        SLD_RUN  = 3'b100
    } sld_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } sld_write_t;

    typedef struct packed {
        logic [7:0] digit_sink_lines;
        logic [6:0] segment_source_lines;
        logic       decimal_point;
    } sld_pins_t;
endpackage

// ### sim/sld_ctrl_checker.sv
// Port assertions for the serial LED display controller
`timescale 1ns/1ns
module sld_ctrl_checker
    import sld_pkg::*;
#(
    parameter int WAKE_COUNT  = 20,
    parameter int DIGIT_COUNT = 64
)
(
    // Watched ports
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic       link_clk_in,
    input wire logic       serial_data_in,
    input wire logic       latch_strobe_in,
    input wire logic       serial_data_out,
    input wire logic       serial_data_oe_out,
    input wire logic [7:0] digit_sink_lines_out,
    input wire logic [6:0] segment_source_lines_out,
    input wire logic       decimal_point_out
);
    logic [16:0] hist;
    logic        shut_q;
    logic        test_q;
    logic [7:0]  blank_d;
    logic [7:0]  lit_d;
    logic        blank;
    assign blank = digit_sink_lines_out == 8'hFF
        && segment_source_lines_out == 7'h00 && !decimal_point_out;
    // Top bit is what the cascade output owes at this rising edge
    always_ff @(posedge link_clk_in or negedge rstn_in)
        if (!rstn_in) hist <= '0;
        else hist <= {hist[15:0], serial_data_in};
    always_ff @(posedge latch_strobe_in or negedge rstn_in)
        if (!rstn_in) shut_q <= 1'b1;
        else if (hist[11:8] == ADR_POWER) shut_q <= !hist[POWER_RUN_BIT];
    always_ff @(posedge latch_strobe_in or negedge rstn_in)
        if (!rstn_in) test_q <= 1'b0;
        else if (hist[11:8] == ADR_TEST) test_q <= hist[TEST_BIT];
    // Eight cycles of slack cover the sync and output stages
    always_ff @(posedge clk_in or negedge rstn_in)
        if (!rstn_in) blank_d <= '0;
        else blank_d <= {blank_d[6:0], shut_q & !test_q};
    always_ff @(posedge clk_in or negedge rstn_in)
        if (!rstn_in) lit_d <= '0;
        else lit_d <= {lit_d[6:0], test_q};

    a_drive_always: assert property (
        @(posedge clk_in) disable iff (!rstn_in) serial_data_oe_out)
        else $error("cascade output not driven");
    a_reset_blank: assert property (
        @(posedge clk_in) disable iff (!rstn_in) $rose(rstn_in) |-> blank)
        else $error("display lit after reset");
    a_link_echo: assert property (
        @(posedge link_clk_in) disable iff (!rstn_in)
        serial_data_out == hist[16])
        else $error("cascade output not 16.5 clocks behind input");
    a_shut_blank: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(latch_strobe_in) && hist[11:8] == ADR_POWER
        && !hist[POWER_RUN_BIT] && !lit_d[0] |-> ##[1:8] blank)
        else $error("shutdown write did not blank");
    a_stay_blank: assert property (
        @(posedge clk_in) disable iff (!rstn_in) &blank_d |-> blank)
        else $error("display lit in shutdown");
    a_test_lit: assert property (
        @(posedge clk_in) disable iff (!rstn_in) &lit_d
        |-> segment_source_lines_out == 7'h7F && decimal_point_out)
        else $error("display test not lighting all segments");
    a_one_digit: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        $onehot0(~digit_sink_lines_out))
        else $error("more than one digit line sunk");
    a_wake_delay: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(latch_strobe_in) && hist[11:8] == ADR_POWER
        && hist[POWER_RUN_BIT] && blank_d[0]
        |-> ##1 (digit_sink_lines_out == 8'hFF) [*8])
        else $error("display woke too early");
endmodule // sld_ctrl_checker

bind sld_ctrl sld_ctrl_checker #(
    .WAKE_COUNT(WAKE_COUNT),
    .DIGIT_COUNT(DIGIT_COUNT)
) u_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk_in),
    .serial_data_in(serial_data_in), .latch_strobe_in(latch_strobe_in),
    .serial_data_out(serial_data_out),
    .serial_data_oe_out(serial_data_oe_out),
    .digit_sink_lines_out(digit_sink_lines_out),
    .segment_source_lines_out(segment_source_lines_out),
    .decimal_point_out(decimal_point_out)
);

// ### sim/sld_host.sv
// Host model that clocks frames into the controller
`timescale 1ns/1ns
module sld_host
(
    // Serial link
    output logic link_clk_out,
    output logic data_out,
    output logic latch_out
);
    initial
    begin
        link_clk_out = 1'b0;
        data_out = 1'b0;
        latch_out = 1'b0;
    end
    // Link clock stands still between frames
    task automatic send(input logic [15:0] frame);
        for (int i = 15; i >= 0; i--)
        begin
            data_out = frame[i];
            #24 link_clk_out = 1'b1;
            #24 link_clk_out = 1'b0;
        end
        data_out = ~frame[0];
        #12 latch_out = 1'b1;
        #60 latch_out = 1'b0;
        #400;
    endtask
endmodule // sld_host

// ### sim/tb_top.sv
// Testbench for the serial LED display controller
`timescale 1ns/1ns
module tb_top;
    import sld_pkg::*;
    localparam logic [6:0] FONT [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79,
        7'h33, 7'h5B, 7'h5F, 7'h70, 7'h7F, 7'h7B, 7'h01, 7'h4F,
        7'h37, 7'h0E, 7'h67, 7'h00};
    localparam int WAKE_N = 20;
    localparam int DIG_N  = 64;
    logic       clk_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       lclk;
    logic       sdi;
    logic       latch;
    logic       dp;
    logic       sdo;
    logic       oe;
    logic [7:0] dig;
    logic [6:0] seg;
    int         n_fail = 0;
    int         check_count = 0;

    sld_host host (.link_clk_out(lclk), .data_out(sdi), .latch_out(latch));
    sld_ctrl #(.WAKE_COUNT(WAKE_N), .DIGIT_COUNT(DIG_N)) dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .link_clk_in(lclk),
        .serial_data_in(sdi), .latch_strobe_in(latch),
        .serial_data_out(sdo), .serial_data_oe_out(oe),
        .digit_sink_lines_out(dig), .segment_source_lines_out(seg),
        .decimal_point_out(dp));

    always #20 clk_in = ~clk_in;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits for a digit line to be sunk, then compares dp and segments
    task automatic show(input int idx, input logic [7:0] exp);
        int k;
        k = 0;
        while (dig !== ~(8'h01 << idx) && k < 4000)
        begin
            @(posedge clk_in);
            #2 k++;
        end
        check(dig, ~(8'h01 << idx));
        check({dp, seg}, exp);
    endtask
    // Lit cycles over one full pwm period, any digit
    task automatic duty(input logic [3:0] lvl);
        int n;
        n = 0;
        repeat (DIG_N)
        begin
            @(posedge clk_in);
            #2;
            if (dig !== 8'hFF)
                n++;
        end
        check(8'(n), 8'((DIG_N / PWM_STEPS) * (2 * lvl + 1)));
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk_in);
        #2 rstn_in = 1'b1;
        check(dig, 8'hFF);
        check({dp, seg}, 8'h00);
        host.send(16'h0A0F);
        check({6'h00, oe, sdo}, 8'h02);
        host.send(16'h0C01);
        check({6'h00, oe, sdo}, 8'h03);
        check(dig, 8'hFF);
        host.send(16'h01B6);
        show(0, 8'hB6);
        host.send(16'h0901);
        for (int i = 0; i < 16; i++)
        begin
            host.send({i[3:0], ADR_DIGIT0, i[0], 3'b101, i[3:0]});
            show(0, {i[0], FONT[i]});
        end
        host.send(16'h0900);
        host.send(16'h0B01);
        host.send(16'h024F);
        show(1, 8'h4F);
        show(0, 8'hDF);
        host.send(16'h0055);
        host.send(16'h0D55);
        show(0, 8'hDF);
        host.send(16'h0902);
        show(1, 8'h00);
        show(0, 8'hDF);
        host.send(16'h0900);
        host.send(16'h0C00);
        check({dig[0], dp, seg}, 9'h100);
        host.send(16'h0135);
        check(dig, 8'hFF);
        host.send(16'h0F01);
        check({dp, seg}, 8'hFF);
        host.send(16'h0F00);
        check({dp, seg}, 8'h00);
        host.send(16'h0C01);
        show(0, 8'h35);
        show(1, 8'h4F);
        host.send(16'h0A00);
        duty(4'h0);
        host.send(16'h0A07);
        duty(4'h7);
        test_done();
    end

    initial
    begin
        #2_000_000;
        n_fail++;
        test_done();
    end
endmodule // tb_top
